//--- hdl/sttd_pkg.sv
package sttd_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 24;
  localparam int unsigned N_EVT  = 1;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_WRAP  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LIVE  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ISTAT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IEN   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ICLR  = 8'h14;

  //////////////////////////////////////////////////////////////////////////////
  // Control register field positions
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_IRQEN_BIT  = 1;
  localparam int unsigned CTRL_CLKSRC_BIT = 2;
  localparam int unsigned CTRL_FLAG_BIT   = 16;

  //////////////////////////////////////////////////////////////////////////////
  // Values after reset, and the largest count value
  localparam logic [2:0]       CTRL_RESET = 3'h0;
  localparam logic [N_EVT-1:0] IEN_RESET  = 1'h0;
  localparam logic [CNT_W-1:0] CNT_MAX    = 24'hFF_FFFF;

  //////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic              sel;
    logic              enable;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sttd_apb_req_t;

  typedef struct packed {
    logic clk_source;
    logic tick_irq_enable;
    logic enable;
  } sttd_ctrl_t;

  typedef enum {ST_IDLE, ST_ACCESS} sttd_apb_st_t;

  typedef enum {REG_CTRL, REG_WRAP, REG_LIVE, REG_ISTAT, REG_IEN, REG_ICLR, REG_NONE} sttd_reg_t;

endpackage

//--- hdl/sttd_counter.sv
module sttd_counter #(
  parameter int unsigned CNT_W = 24
) (
  // Clock
  input  wire logic             i_core_clk,
  // Control
  input  wire logic             i_run,
  input  wire logic             i_clear,
  input  wire logic [CNT_W-1:0] i_wrap,
  // Status
  output logic      [CNT_W-1:0] o_count,
  output logic                  o_tick
);

  logic [CNT_W-1:0] count_q;

  // Tick only on the step from one to zero; a clear never ticks
  assign o_tick  = i_run & ~i_clear & (count_q == CNT_W'(1));
  assign o_count = count_q;

  // No reset: the count is undefined until software clears it
  always_ff @(posedge i_core_clk) begin
    if (i_clear) begin
      count_q <= '0;
    end else if (i_run) begin
      if (count_q == '0) begin
        count_q <= i_wrap;
      end else begin
        count_q <= count_q - CNT_W'(1);
      end
    end
  end

endmodule

//--- hdl/sttd_irq.sv
module sttd_irq #(
  parameter int unsigned N_EVT = 1
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_reset_n,
  // Events and software access
  input  wire logic [N_EVT-1:0] i_event,
  input  wire logic             i_enable_wr,
  input  wire logic             i_clear_wr,
  input  wire logic [N_EVT-1:0] i_wdata,
  // State
  output logic      [N_EVT-1:0] o_status,
  output logic      [N_EVT-1:0] o_enable,
  output logic                  o_irq
);

  logic [N_EVT-1:0] status_d;
  logic [N_EVT-1:0] status_q;
  logic [N_EVT-1:0] enable_d;
  logic [N_EVT-1:0] enable_q;
  logic             irq_q;

  // Sticky bits, set wins over a clear in the same cycle
  for (genvar g = 0; g < N_EVT; g++) begin : g_bit
    assign status_d[g] = i_event[g] | (status_q[g] & ~(i_clear_wr & i_wdata[g]));
  end

  assign enable_d = i_enable_wr ? i_wdata : enable_q;

  // Irq computed from next values so it tracks the status without lag
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      status_q <= '0;
      enable_q <= sttd_pkg::IEN_RESET;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      enable_q <= enable_d;
      irq_q    <= |(status_d & enable_d);
    end
  end

  assign o_status = status_q;
  assign o_enable = enable_q;
  assign o_irq    = irq_q;

endmodule

//--- hdl/sttd_top.sv
// Function
// [R1] Wrap value 1..FFFFFF reloads at zero
// [R2] Wrap field is bits 23:0, rest reserved
// [R3] Wrap value zero never produces ticks
// [R4] Flag and irq only on one-to-zero step
// [R5] Repeating ticks every wrap plus one cycles
// [R6] Single-shot software rewrites real count each tick
// [R7] Live count read returns current counter value
// [R8] Any live count write clears the count
// [R9] Live count write also clears the flag
// [R10] Upper bits 31:24 read as zero
// [R11] No calibration register is provided
// [R12] Wrap and count undefined after reset
// [R13] Decrement to zero, reload next edge
// [R14] Control register read clears the flag
// [R15] Tick irq enable raises request at zero
// [R16] Counter holds while enable is clear
module sttd_top (
  // Clock and reset
  input  wire logic                          i_core_clk,
  input  wire logic                          i_reset_n,
  // APB slave
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [sttd_pkg::ADDR_W-1:0]   i_paddr,
  input  wire logic [sttd_pkg::DATA_W-1:0]   i_pwdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  output logic      [sttd_pkg::DATA_W-1:0]   o_prdata,
  // Interrupt
  output logic                               o_irq
);

  localparam int unsigned CW = sttd_pkg::CNT_W;
  localparam int unsigned NE = sttd_pkg::N_EVT;
  localparam int unsigned DW = sttd_pkg::DATA_W;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the read and write paths
  function automatic sttd_pkg::sttd_reg_t decode(input logic [sttd_pkg::ADDR_W-1:0] a);
    sttd_pkg::sttd_reg_t r;
    // [R11] no calibration word
    // Any other offset, calibration included, is unmapped
    case (a)
      sttd_pkg::OFS_CTRL:  r = sttd_pkg::REG_CTRL;
      sttd_pkg::OFS_WRAP:  r = sttd_pkg::REG_WRAP;
      sttd_pkg::OFS_LIVE:  r = sttd_pkg::REG_LIVE;
      sttd_pkg::OFS_ISTAT: r = sttd_pkg::REG_ISTAT;
      sttd_pkg::OFS_IEN:   r = sttd_pkg::REG_IEN;
      sttd_pkg::OFS_ICLR:  r = sttd_pkg::REG_ICLR;
      default:             r = sttd_pkg::REG_NONE;
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  sttd_pkg::sttd_apb_req_t req;
  sttd_pkg::sttd_apb_st_t  st_q;
  sttd_pkg::sttd_reg_t     sel_reg;
  sttd_pkg::sttd_ctrl_t    ctrl_q;

  logic          pready_q;
  logic          pslverr_q;
  logic [DW-1:0] prdata_q;
  logic [DW-1:0] rd_word;

  logic          setup;
  logic          done;
  logic          rd_setup;
  logic          wr_done;
  logic          wr_ctrl;
  logic          wr_wrap;
  logic          wr_live;
  logic          wr_ien;
  logic          wr_iclr;
  logic          rd_ctrl;

  logic          flag_q;
  logic [CW-1:0] wrap_q;
  logic [CW-1:0] count;
  logic          tick;
  logic          run;

  logic [NE-1:0] irq_evt;
  logic [NE-1:0] irq_status;
  logic [NE-1:0] irq_enable;
  logic          irq;

  //////////////////////////////////////////////////////////////////////////////
  // Bus request bundle
  assign req = '{sel:    i_psel,
                 enable: i_penable,
                 write:  i_pwrite,
                 addr:   i_paddr,
                 wdata:  i_pwdata};

  assign sel_reg  = decode(req.addr);
  assign setup    = req.sel & ~req.enable & (st_q == sttd_pkg::ST_IDLE);
  assign done     = req.sel & req.enable & pready_q;
  assign rd_setup = setup & ~req.write;
  assign wr_done  = done & req.write;

  // Write strobes fire at the completing edge only
  assign wr_ctrl = wr_done & (sel_reg == sttd_pkg::REG_CTRL);
  assign wr_wrap = wr_done & (sel_reg == sttd_pkg::REG_WRAP);
  assign wr_live = wr_done & (sel_reg == sttd_pkg::REG_LIVE);
  assign wr_ien  = wr_done & (sel_reg == sttd_pkg::REG_IEN);
  assign wr_iclr = wr_done & (sel_reg == sttd_pkg::REG_ICLR);

  // Read side effect at the capture edge, so data and clear agree
  assign rd_ctrl = rd_setup & (sel_reg == sttd_pkg::REG_CTRL);

  //////////////////////////////////////////////////////////////////////////////
  // APB phase tracking, one wait-free access cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      st_q     <= sttd_pkg::ST_IDLE;
      pready_q <= 1'b0;
    end else begin
      unique case (st_q)
        sttd_pkg::ST_IDLE: begin
          if (setup) begin
            st_q     <= sttd_pkg::ST_ACCESS;
            pready_q <= 1'b1;
          end
        end
        sttd_pkg::ST_ACCESS: begin
          if (done) begin
            st_q     <= sttd_pkg::ST_IDLE;
            pready_q <= 1'b0;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read word mux
  always_comb begin
    rd_word = '0;
    unique case (sel_reg)
      sttd_pkg::REG_CTRL: begin
        rd_word[sttd_pkg::CTRL_FLAG_BIT]   = flag_q;
        rd_word[sttd_pkg::CTRL_CLKSRC_BIT] = ctrl_q.clk_source;
        rd_word[sttd_pkg::CTRL_IRQEN_BIT]  = ctrl_q.tick_irq_enable;
        rd_word[sttd_pkg::CTRL_ENABLE_BIT] = ctrl_q.enable;
      end
      // [R10] upper byte zero
      sttd_pkg::REG_WRAP:  rd_word[CW-1:0] = wrap_q;
      // [R7] live count sample
      sttd_pkg::REG_LIVE:  rd_word[CW-1:0] = count;
      sttd_pkg::REG_ISTAT: rd_word[NE-1:0] = irq_status;
      sttd_pkg::REG_IEN:   rd_word[NE-1:0] = irq_enable;
      sttd_pkg::REG_ICLR:  rd_word = '0;
      sttd_pkg::REG_NONE:  rd_word = '0;
    endcase
  end

  // Data and error registered at the setup edge
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= req.write ? '0 : rd_word;
      pslverr_q <= (sel_reg == sttd_pkg::REG_NONE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ctrl_q <= sttd_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q.clk_source      <= req.wdata[sttd_pkg::CTRL_CLKSRC_BIT];
      ctrl_q.tick_irq_enable <= req.wdata[sttd_pkg::CTRL_IRQEN_BIT];
      ctrl_q.enable          <= req.wdata[sttd_pkg::CTRL_ENABLE_BIT];
    end
  end

  // [R16] hold unless enabled
  // Only the core clock source exists, so it must be selected too
  assign run = ctrl_q.enable & ctrl_q.clk_source;

  //////////////////////////////////////////////////////////////////////////////
  // Wrap value register
  // [R12] no reset value
  // [R2] low field only
  always_ff @(posedge i_core_clk) begin
    if (wr_wrap) begin
      wrap_q <= req.wdata[CW-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Down counter
  // [R1] reload at zero
  // [R13] decrement then reload
  // [R8] write clears count
  // [R3] zero wrap never ticks
  sttd_counter #(
    .CNT_W      (CW)
  ) u_counter (
    .i_core_clk (i_core_clk),
    .i_run      (run),
    .i_clear    (wr_live),
    .i_wrap     (wrap_q),
    .o_count    (count),
    .o_tick     (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Zero-reached flag
  // [R4] set on tick only
  // [R14] read clears flag
  // [R9] live write clears flag
  // A tick in the clearing cycle wins, so no event is lost
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      flag_q <= 1'b0;
    end else if (tick) begin
      flag_q <= 1'b1;
    end else if (rd_ctrl | wr_live) begin
      flag_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and clear
  // [R15] gated tick request
  assign irq_evt = NE'(tick & ctrl_q.tick_irq_enable);

  sttd_irq #(
    .N_EVT       (NE)
  ) u_irq (
    .i_core_clk  (i_core_clk),
    .i_reset_n   (i_reset_n),
    .i_event     (irq_evt),
    .i_enable_wr (wr_ien),
    .i_clear_wr  (wr_iclr),
    .i_wdata     (req.wdata[NE-1:0]),
    .o_status    (irq_status),
    .o_enable    (irq_enable),
    .o_irq       (irq)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_pready  = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_prdata  = prdata_q;
  assign o_irq     = irq;

  //////////////////////////////////////////////////////////////////////////////
  // Tick spacing monitor for the period check
  // Only run cycles count, since a stopped counter holds its place
  // A wrap or live write outside a tick cycle breaks the period, so the check waits a tick
  logic          gap_valid_q;
  logic [CW-1:0] gap_q;

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      gap_valid_q <= 1'b0;
      gap_q       <= '0;
    end else if (tick) begin
      gap_valid_q <= 1'b1;
      gap_q       <= '0;
    end else if (wr_live | wr_wrap) begin
      gap_valid_q <= 1'b0;
    end else if (run) begin
      gap_q <= gap_q + CW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  reload_at_zero_a: // [R1]
    assert property (run && !wr_live && count == '0 |=> count == $past(wrap_q))
      else $error("counter did not reload wrap value at zero");

  wrap_field_a: // [R2]
    assert property (wr_wrap |=> wrap_q == $past(req.wdata[CW-1:0]))
      else $error("wrap field not stored from bits 23:0");

  zero_wrap_a: // [R3]
    assert property (run && wrap_q == '0 && count == '0 |=> count == '0 && !tick)
      else $error("tick produced with zero wrap value");

  flag_cause_a: // [R4]
    assert property ($rose(flag_q) |-> $past(count) == CW'(1) && $past(run))
      else $error("flag rose without a one-to-zero step");

  tick_period_a: // [R5]
    assert property (tick && gap_valid_q |-> gap_q == wrap_q)
      else $error("tick period not wrap plus one");

  live_read_a: // [R7]
    assert property (rd_setup && sel_reg == sttd_pkg::REG_LIVE
                     |=> o_prdata[CW-1:0] == $past(count) && o_pready)
      else $error("live count read returned wrong value");

  live_clear_a: // [R8]
    assert property (wr_live |=> count == '0 && !flag_q)
      else $error("live write did not clear count and flag");

  upper_zero_a: // [R10]
    assert property (o_pready && (sel_reg == sttd_pkg::REG_WRAP || sel_reg == sttd_pkg::REG_LIVE)
                     |-> o_prdata[DW-1:CW] == '0)
      else $error("reserved upper bits read nonzero");

  unmapped_err_a: // [R11]
    assert property (rd_setup && sel_reg == sttd_pkg::REG_NONE |=> o_pslverr && o_prdata == '0)
      else $error("unmapped offset answered without error");

  flag_read_a: // [R14]
    assert property (rd_ctrl && !tick |=> !flag_q ##1 (o_prdata[sttd_pkg::CTRL_FLAG_BIT] == $past(flag_q, 2)))
      else $error("control read did not clear flag");

  tick_irq_a: // [R15]
    assert property (tick && ctrl_q.tick_irq_enable && irq_enable[0] && !wr_ien |=> o_irq)
      else $error("enabled tick did not raise interrupt");

  irq_level_a: // [R15]
    assert property (o_irq == |(irq_status & irq_enable))
      else $error("interrupt line differs from enabled status");

  hold_count_a: // [R16]
    assert property (!run && !wr_live |=> $stable(count))
      else $error("counter moved while disabled");

  apb_done_a:
    assert property (setup |=> o_pready ##1 !o_pready)
      else $error("apb access did not complete in one cycle");

  tick_seen_c:    cover property (tick ##[1:20] tick);
  irq_seen_c:     cover property ($rose(o_irq));
  flag_read_c:    cover property (flag_q && rd_ctrl);
  live_clear_c:   cover property (run && wr_live);
  period_chk_c:   cover property (tick && gap_valid_q);

endmodule

//--- verification/test_system_tick_down_counter.sv
module test_system_tick_down_counter;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    string       name;
    logic [31:0] data;
    logic        err;
  } sttd_note_t;

  logic                            clk;
  logic                            rst_n;
  logic                            psel;
  logic                            penable;
  logic                            pwrite;
  logic [sttd_pkg::ADDR_W-1:0]     paddr;
  logic [sttd_pkg::DATA_W-1:0]     pwdata;
  logic                            pready;
  logic                            pslverr;
  logic [sttd_pkg::DATA_W-1:0]     prdata;
  logic                            irq;
  int                              n_mismatch = 0;
  int                              cmp_count  = 0;
  int                              cyc        = 0;
  int                              wrap_n;
  int                              t1;
  int                              t2;
  logic [31:0]                     rnd;
  sttd_note_t                      notes[$];
  sttd_note_t                      mon_note;

  //////////////////////////////////////////////////////////////////////////////
  // Clock and free cycle count
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  sttd_top dut (
    .i_core_clk (clk),
    .i_reset_n  (rst_n),
    .i_psel     (psel),
    .i_penable  (penable),
    .i_pwrite   (pwrite),
    .i_paddr    (paddr),
    .i_pwdata   (pwdata),
    .o_pready   (pready),
    .o_pslverr  (pslverr),
    .o_prdata   (prdata),
    .o_irq      (irq)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Shared compare and verdict
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Bus master: one idle edge after each transfer keeps drives one per step
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     input logic [31:0] exp, input logic exp_err, input string nm);
    int n;
    n = 0;
    notes.push_back('{nm, exp, exp_err});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Waits for the answer however long; only the watchdog ends a hang
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    chk("access cycles", 32'h0000_0001, n);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
    apb(1'b1, addr, wd, 32'h0000_0000, 1'b0, "write answer");
  endtask

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input string nm);
    apb(1'b0, addr, 32'h0000_0000, exp, 1'b0, nm);
  endtask

  // Bounded wait for the interrupt line, stamped with the cycle count
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) chk("irq wait", 1, 0);
    t = cyc;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Monitor: every completed transfer takes the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) chk("answer without note", 0, 1);
      else begin
        mon_note = notes.pop_front();
        chk(mon_note.name, mon_note.data, prdata);
        chk("pslverr", {31'h0, mon_note.err}, {31'h0, pslverr});
      end
    end
  end

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #100_000;
    n_mismatch++;
    close_out();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    void'($urandom(75795));
    wrap_n = 6 + ($urandom % 20);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;

    // Reset values, unmapped and absent calibration place
    rd(sttd_pkg::OFS_CTRL, 32'h0000_0000, "ctrl reset");
    rd(sttd_pkg::OFS_ISTAT, 32'h0000_0000, "istat reset");
    rd(sttd_pkg::OFS_IEN, 32'h0000_0000, "ien reset");
    rd(sttd_pkg::OFS_ICLR, 32'h0000_0000, "iclr reads zero");
    apb(1'b0, 8'h18, 32'h0000_0000, 32'h0000_0000, 1'b1, "unmapped read");
    apb(1'b1, 8'h18, 32'h0000_0001, 32'h0000_0000, 1'b1, "unmapped write");
    chk("irq after reset", 0, irq);
    $display("test reset done");

    // Wrap field width and reserved upper byte
    wr(sttd_pkg::OFS_WRAP, 32'hFFFF_FFFF);
    rd(sttd_pkg::OFS_WRAP, 32'h00FF_FFFF, "wrap max");
    rnd = $urandom;
    wr(sttd_pkg::OFS_WRAP, rnd);
    rd(sttd_pkg::OFS_WRAP, rnd & 32'h00FF_FFFF, "wrap random");
    wr(sttd_pkg::OFS_LIVE, $urandom | 32'hFF00_0001);
    rd(sttd_pkg::OFS_LIVE, 32'h0000_0000, "live cleared");
    repeat (5) @(posedge clk);
    rd(sttd_pkg::OFS_LIVE, 32'h0000_0000, "live held");
    $display("test registers done");

    // Start from zero, load on next edge, stop two edges later
    wr(sttd_pkg::OFS_WRAP, wrap_n);
    wr(sttd_pkg::OFS_IEN, 32'h0000_0001);
    wr(sttd_pkg::OFS_CTRL, 32'h0000_0007);
    wr(sttd_pkg::OFS_CTRL, 32'h0000_0006);
    rd(sttd_pkg::OFS_LIVE, wrap_n - 2, "live stopped");
    rd(sttd_pkg::OFS_CTRL, 32'h0000_0006, "no flag yet");
    $display("test load done");

    // Repeating ticks: period, interrupt clear and masking
    wr(sttd_pkg::OFS_CTRL, 32'h0000_0007);
    wait_irq(t1);
    wr(sttd_pkg::OFS_ICLR, 32'h0000_0001);
    wait_irq(t2);
    chk("tick period", wrap_n + 1, t2 - t1);
    rd(sttd_pkg::OFS_ISTAT, 32'h0000_0001, "istat set");
    wr(sttd_pkg::OFS_IEN, 32'h0000_0000);
    wr(sttd_pkg::OFS_ICLR, 32'h0000_0001);
    repeat (wrap_n + 3) begin
      @(posedge clk);
      chk("irq masked", 0, irq);
    end
    rd(sttd_pkg::OFS_ISTAT, 32'h0000_0001, "istat while masked");
    wr(sttd_pkg::OFS_IEN, 32'h0000_0001);
    @(posedge clk);
    chk("irq unmasked", 1, irq);
    $display("test period done");

    // Live write clears the flag without a control read
    wr(sttd_pkg::OFS_CTRL, 32'h0000_0006);
    wr(sttd_pkg::OFS_LIVE, 32'h0000_0055);
    rd(sttd_pkg::OFS_CTRL, 32'h0000_0006, "flag after live write");
    // Control read clears the flag
    wr(sttd_pkg::OFS_ICLR, 32'h0000_0001);
    wr(sttd_pkg::OFS_CTRL, 32'h0000_0007);
    wait_irq(t1);
    wr(sttd_pkg::OFS_CTRL, 32'h0000_0006);
    rd(sttd_pkg::OFS_CTRL, 32'h0001_0006, "flag set");
    rd(sttd_pkg::OFS_CTRL, 32'h0000_0006, "flag read clear");
    $display("test flag done");

    // Zero wrap value never ticks; clearing to zero is no tick either
    wr(sttd_pkg::OFS_WRAP, 32'h0000_0000);
    wr(sttd_pkg::OFS_LIVE, 32'h0000_0000);
    wr(sttd_pkg::OFS_ICLR, 32'h0000_0001);
    wr(sttd_pkg::OFS_CTRL, 32'h0000_0007);
    repeat (40) begin
      @(posedge clk);
      chk("irq with zero wrap", 0, irq);
    end
    rd(sttd_pkg::OFS_ISTAT, 32'h0000_0000, "istat zero wrap");
    rd(sttd_pkg::OFS_CTRL, 32'h0000_0007, "flag zero wrap");
    $display("test zero wrap done");

    // Single shot: at the start and at the first interrupt software loads the real count and
    // clears the live value; tick follows the clear edge by that count plus one cycles
    repeat (2) begin
      wrap_n = 8 + ($urandom % 16);
      wr(sttd_pkg::OFS_WRAP, wrap_n);
      wr(sttd_pkg::OFS_LIVE, 32'h0000_0000);
      t1 = cyc;
      wr(sttd_pkg::OFS_ICLR, 32'h0000_0001);
      wait_irq(t2);
      chk("single shot span", wrap_n + 1, t2 - t1);
    end
    $display("test single shot done");

    repeat (3) @(posedge clk);
    chk("notes left", 0, notes.size());
    close_out();
  end

endmodule
